/* rtl/lvdc_cfg.svh */
/*
  lvdc_cfg.svh - constants for the supply monitor status/control block:
  register offsets, field positions, reset values and timing figures.
  Assumes it is included by its bare name from files under rtl/.
*/
`ifndef LVDC_CFG_SVH
`define LVDC_CFG_SVH

// register offsets (word index on the plain register port)
`define LVDC_ADDR_W          4
`define LVDC_OFF_CTRL        4'h0
`define LVDC_OFF_IRQ_STATUS  4'h1
`define LVDC_OFF_IRQ_MASK    4'h2
`define LVDC_OFF_LIVE        4'h3

// field positions of the status/control register
`define LVDC_BIT_WARN_FLAG   7
`define LVDC_BIT_WARN_ACK    6
`define LVDC_BIT_WARN_IE     5
`define LVDC_BIT_RST_EN      4
`define LVDC_BIT_STOP_EN     3
`define LVDC_BIT_DET_EN      2
`define LVDC_BIT_BG_EN       0

// reset values of the control fields
`define LVDC_RST_WARN_IE     1'b0
`define LVDC_RST_RST_EN      1'b1
`define LVDC_RST_STOP_EN     1'b1
`define LVDC_RST_DET_EN      1'b1
`define LVDC_RST_BG_EN       1'b0

// interrupt status/mask bit positions
`define LVDC_IRQ_WARN        0
`define LVDC_IRQ_DETECT      1
`define LVDC_IRQ_W           2

// length of the forced system reset pulse and the clock period it is counted in
`define LVDC_RST_PULSE_NS    100
`define LVDC_CLK_NS          10

`endif

/* rtl/lvdc_pkg.sv */
/*
  lvdc_pkg.sv - types shared by the supply monitor control block.
  Assumes lvdc_cfg.svh is available on the include path.
*/
package lvdc_pkg;

  // state of the forced reset pulse generator
  typedef enum logic [0:0] {
    LVDC_RST_IDLE,
    LVDC_RST_PULSE
  } lvdc_rst_state_t;

endpackage

/* rtl/lvdc_sync2.sv */
/*
  lvdc_sync2.sv - two flip-flop synchroniser for level inputs.
  Assumes asynchronous inputs from the analogue comparators.
*/
`timescale 1ns/1ps
module lvdc_sync2 #(
  parameter int WIDTH = 2
) (
  // clock and reset
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst,
  // levels
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // two stages, first read only by second
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule // lvdc_sync2

/* rtl/lvdc_once.sv */
/*
  lvdc_once.sv - write-once control bits, locked after the first write.
  Assumes a one-cycle write strobe from the register decoder.
*/
`timescale 1ns/1ps
module lvdc_once #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst,
  // write port
  input  wire logic             i_wr,
  input  wire logic [WIDTH-1:0] i_wdata,
  output logic      [WIDTH-1:0] o_value
);

  logic [WIDTH-1:0] val_q;
  logic [WIDTH-1:0] val_d;
  logic             lock_q;
  logic             lock_d;

  // first write after reset commits, later ones ignored
  always_comb begin
    val_d  = val_q;
    lock_d = lock_q;
    if (i_wr && !lock_q) begin
      val_d  = i_wdata;
      lock_d = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      val_q  <= RESET_VAL;
      lock_q <= 1'b0;
    end else begin
      val_q  <= val_d;
      lock_q <= lock_d;
    end
  end

  assign o_value = val_q;

endmodule // lvdc_once

/* rtl/lvdc_top.sv */
/*
  lvdc_top.sv - supply monitor status/control register logic: warning
  flag, write-once detector controls, bandgap buffer enable, interrupt
  and forced reset request.
  Assumes asynchronous comparator levels and a single-cycle register port.
*/
// Function
// - the warning flag in bit 7 sets while the warning comparator is low and stays set.
// - the flag sets on entering the warning condition, including right after reset.
// - writing 1 to bit 6 clears the flag only when no warning is present.
// - with bit 5 set an interrupt is requested while the flag is 1.
// - with bit 4 and the detector enabled a detect event forces a system reset.
// - bit 3 decides if the detector runs in stop mode, given the detector is on.
// - bit 2 turns detection on and gates the reset and stop enables.
// - the detector, stop and reset enables accept only the first write after reset.
// - bit 0 drives the bandgap reference buffer enable.
`timescale 1ns/1ps
`include "lvdc_cfg.svh"
module lvdc_top #(
  parameter int RST_PULSE_CYC = (`LVDC_RST_PULSE_NS + `LVDC_CLK_NS - 1) / `LVDC_CLK_NS
) (
  // clock and reset
  input  wire logic                    i_sys_clk,
  input  wire logic                    i_rst,
  // register port
  input  wire logic [`LVDC_ADDR_W-1:0] i_addr,
  input  wire logic [7:0]              i_wdata,
  input  wire logic                    i_wr,
  input  wire logic                    i_rd,
  output logic      [7:0]              o_rdata,
  // analogue comparators and mode
  input  wire logic                    i_warn_low,
  input  wire logic                    i_detect_low,
  input  wire logic                    i_stop_mode,
  // controls to analogue and reset controller, and interrupt request
  output logic                         o_detector_on,
  output logic                         o_bandgap_buffer_enable,
  output logic                         o_sys_reset_req,
  output logic                         o_irq
);

  localparam int CW = $clog2(RST_PULSE_CYC + 1);

  logic [1:0] comp_sync;
  logic       warn_s;
  logic       det_s;
  logic [2:0] once_val;
  logic       det_en;
  logic       stop_en;
  logic       rst_en;

  logic       warn_flag_q, warn_flag_d;
  logic       warn_ie_q, warn_ie_d;
  logic       bg_en_q, bg_en_d;
  logic       det_prev_q, det_prev_d;
  logic [`LVDC_IRQ_W-1:0] irq_stat_q, irq_stat_d;
  logic [`LVDC_IRQ_W-1:0] irq_mask_q, irq_mask_d;
  logic [7:0] rdata_q, rdata_d;
  logic       irq_q, irq_d;
  logic       det_on_q, det_on_d;
  logic       bg_out_q, bg_out_d;
  logic       sreq_q, sreq_d;
  lvdc_pkg::lvdc_rst_state_t rst_st_q, rst_st_d;
  logic [CW-1:0] rst_cnt_q, rst_cnt_d;

  // address decode used by read and write paths
  function automatic logic hit(input logic [`LVDC_ADDR_W-1:0] a,
                               input logic [`LVDC_ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  // comparator levels into the clock domain
  lvdc_sync2 #(.WIDTH(2)) u_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_async   ({i_detect_low, i_warn_low}),
    .o_sync    (comp_sync)
  );
  assign warn_s = comp_sync[0];
  assign det_s  = comp_sync[1];

  lvdc_once #(
    .WIDTH     (3),
    .RESET_VAL ({`LVDC_RST_RST_EN, `LVDC_RST_STOP_EN, `LVDC_RST_DET_EN})
  ) u_once (
    .i_sys_clk (i_sys_clk),
    .i_rst     (i_rst),
    .i_wr      (i_wr && hit(i_addr, `LVDC_OFF_CTRL)),
    .i_wdata   ({i_wdata[`LVDC_BIT_RST_EN], i_wdata[`LVDC_BIT_STOP_EN],
                 i_wdata[`LVDC_BIT_DET_EN]}),
    .o_value   (once_val)
  );
  assign det_en  = once_val[0];
  assign stop_en = once_val[1];
  assign rst_en  = once_val[2];

  // register state, flag and interrupt status
  always_comb begin
    warn_flag_d = warn_flag_q;
    warn_ie_d   = warn_ie_q;
    bg_en_d     = bg_en_q;
    irq_mask_d  = irq_mask_q;
    irq_stat_d  = irq_stat_q;
    det_prev_d  = det_s;
    if (i_wr && hit(i_addr, `LVDC_OFF_CTRL)) begin
      warn_ie_d = i_wdata[`LVDC_BIT_WARN_IE];
      bg_en_d   = i_wdata[`LVDC_BIT_BG_EN];
      if (i_wdata[`LVDC_BIT_WARN_ACK] && !warn_s) begin
        warn_flag_d = 1'b0;
      end
    end
    if (i_wr && hit(i_addr, `LVDC_OFF_IRQ_MASK)) begin
      irq_mask_d = i_wdata[`LVDC_IRQ_W-1:0];
    end
    if (i_wr && hit(i_addr, `LVDC_OFF_IRQ_STATUS)) begin
      irq_stat_d = irq_stat_q & ~i_wdata[`LVDC_IRQ_W-1:0];
    end
    if (warn_s) begin
      warn_flag_d = 1'b1;
    end
    // sticky event bits, set beats clear
    if (warn_s) begin
      irq_stat_d[`LVDC_IRQ_WARN] = 1'b1;
    end
    if (det_s && !det_prev_q && det_en) begin
      irq_stat_d[`LVDC_IRQ_DETECT] = 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      warn_flag_q <= 1'b0;
      warn_ie_q   <= `LVDC_RST_WARN_IE;
      bg_en_q     <= `LVDC_RST_BG_EN;
      det_prev_q  <= 1'b0;
      irq_stat_q  <= '0;
      irq_mask_q  <= '0;
    end else begin
      warn_flag_q <= warn_flag_d;
      warn_ie_q   <= warn_ie_d;
      bg_en_q     <= bg_en_d;
      det_prev_q  <= det_prev_d;
      irq_stat_q  <= irq_stat_d;
      irq_mask_q  <= irq_mask_d;
    end
  end

  // forced reset pulse generator
  always_comb begin
    rst_st_d  = rst_st_q;
    rst_cnt_d = rst_cnt_q;
    sreq_d    = 1'b0;
    unique case (rst_st_q)
      lvdc_pkg::LVDC_RST_IDLE: begin
        if (det_s && det_en && rst_en) begin
          rst_st_d  = lvdc_pkg::LVDC_RST_PULSE;
          rst_cnt_d = CW'(RST_PULSE_CYC - 1);
          sreq_d    = 1'b1;
        end
      end
      lvdc_pkg::LVDC_RST_PULSE: begin
        sreq_d = 1'b1;
        if (rst_cnt_q == '0) begin
          rst_st_d = lvdc_pkg::LVDC_RST_IDLE;
          sreq_d   = 1'b0;
        end else begin
          rst_cnt_d = rst_cnt_q - 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      rst_st_q  <= lvdc_pkg::LVDC_RST_IDLE;
      rst_cnt_q <= '0;
      sreq_q    <= 1'b0;
    end else begin
      rst_st_q  <= rst_st_d;
      rst_cnt_q <= rst_cnt_d;
      sreq_q    <= sreq_d;
    end
  end

  // read mux and registered outputs
  always_comb begin
    rdata_d = 8'h00;
    if (i_rd) begin
      if (hit(i_addr, `LVDC_OFF_CTRL)) begin
        // ack and bit 1 read zero
        rdata_d[`LVDC_BIT_WARN_FLAG] = warn_flag_q;
        rdata_d[`LVDC_BIT_WARN_IE]   = warn_ie_q;
        rdata_d[`LVDC_BIT_RST_EN]    = rst_en;
        rdata_d[`LVDC_BIT_STOP_EN]   = stop_en;
        rdata_d[`LVDC_BIT_DET_EN]    = det_en;
        rdata_d[`LVDC_BIT_BG_EN]     = bg_en_q;
      end else if (hit(i_addr, `LVDC_OFF_IRQ_STATUS)) begin
        rdata_d[`LVDC_IRQ_W-1:0] = irq_stat_q;
      end else if (hit(i_addr, `LVDC_OFF_IRQ_MASK)) begin
        rdata_d[`LVDC_IRQ_W-1:0] = irq_mask_q;
      end else if (hit(i_addr, `LVDC_OFF_LIVE)) begin
        rdata_d[`LVDC_IRQ_W-1:0] = {det_s, warn_s};
      end
    end
    irq_d = (warn_ie_q && warn_flag_q) || (|(irq_stat_q & irq_mask_q));
    det_on_d = det_en && (!i_stop_mode || stop_en);
    bg_out_d = bg_en_q;
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      rdata_q  <= 8'h00;
      irq_q    <= 1'b0;
      det_on_q <= 1'b0;
      bg_out_q <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      irq_q    <= irq_d;
      det_on_q <= det_on_d;
      bg_out_q <= bg_out_d;
    end
  end

  assign o_rdata                 = rdata_q;
  assign o_irq                   = irq_q;
  assign o_detector_on           = det_on_q;
  assign o_bandgap_buffer_enable = bg_out_q;
  assign o_sys_reset_req         = sreq_q;

endmodule // lvdc_top

/* tb/lvdc_checker.sv */
/* lvdc_checker.sv - port assertions for lvdc_top.
   Assumes it is bound onto lvdc_top, one clock, async reset. */
`timescale 1ns/1ps
`include "lvdc_cfg.svh"
module lvdc_checker #(
  parameter int RST_PULSE_CYC = 10
) (
  // clock and reset
  input wire logic                    i_sys_clk,
  input wire logic                    i_rst,
  // register port
  input wire logic [`LVDC_ADDR_W-1:0] i_addr,
  input wire logic                    i_rd,
  input wire logic [7:0]              o_rdata,
  // analogue side
  input wire logic                    i_detect_low,
  input wire logic                    i_stop_mode,
  input wire logic                    o_detector_on,
  input wire logic                    o_bandgap_buffer_enable,
  input wire logic                    o_sys_reset_req,
  input wire logic                    o_irq
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  logic rdc_q;
  // marks the cycle that shows control read data
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) rdc_q <= 1'b0;
    else rdc_q <= i_rd && (i_addr == 4'h0);
  end
  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not idle");
  zero_bits_a: assert property (rdc_q |-> !o_rdata[6] && !o_rdata[1])
    else $error("ack or spare bit reads one");
  irq_enable_a: assert property (rdc_q && o_rdata[7] && o_rdata[5] |-> ##[0:1] o_irq)
    else $error("enabled warning without interrupt");
  det_gate_a: assert property (rdc_q && !o_rdata[2] |-> !o_detector_on)
    else $error("detector on while disabled");
  stop_gate_a: assert property (rdc_q && o_rdata[2] && !o_rdata[3] && i_stop_mode
    |=> !o_detector_on)
    else $error("detector on in stop mode");
  bandgap_a: assert property (rdc_q |-> o_bandgap_buffer_enable == o_rdata[0])
    else $error("bandgap enable differs from bit 0");
  rst_pulse_a: assert property ($rose(o_sys_reset_req) |-> o_sys_reset_req[*8])
    else $error("reset pulse too short");
  rst_cause_a: assert property ($rose(o_sys_reset_req) |-> $past(i_detect_low, 2)
    || $past(i_detect_low, 3) || $past(i_detect_low, 4))
    else $error("reset without detect event");
endmodule // lvdc_checker
bind lvdc_top lvdc_checker #(.RST_PULSE_CYC(RST_PULSE_CYC)) chk (.i_sys_clk, .i_rst,
  .i_addr, .i_rd, .o_rdata, .i_detect_low, .i_stop_mode, .o_detector_on,
  .o_bandgap_buffer_enable, .o_sys_reset_req, .o_irq);

/* tb/lvdc_supply_model.sv */
/* lvdc_supply_model.sv - comparator and stop-mode source.
   Assumes the bench sets the wanted levels. */
`timescale 1ns/1ps
module lvdc_supply_model #(
  parameter int LAG_NS = 3
) (
  // levels wanted by the bench
  input  wire logic i_warn_cmd,
  input  wire logic i_detect_cmd,
  input  wire logic i_stop_cmd,
  // comparator outputs and stop mode
  output logic      o_warn_low = 1'b0,
  output logic      o_detect_low = 1'b0,
  output logic      o_stop_mode
);
  // comparators settle after a lag unrelated to the clock
  always @(i_warn_cmd) o_warn_low <= #(LAG_NS) i_warn_cmd;
  always @(i_detect_cmd) o_detect_low <= #(LAG_NS) i_detect_cmd;
  // stop mode is a same-clock level
  assign o_stop_mode = i_stop_cmd;
endmodule // lvdc_supply_model

/* tb/testbench.sv */
/* testbench.sv - self-checking bench for lvdc_top.
   Assumes the supply model and the bound checker. */
`timescale 1ns/1ps
`include "lvdc_cfg.svh"
module testbench;
  logic i_sys_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
  logic warn = 1'b0, det = 1'b0, stop = 1'b0;
  logic [`LVDC_ADDR_W-1:0] i_addr = 4'h0;
  logic [7:0] i_wdata = 8'h00, o_rdata;
  logic i_warn_low, i_detect_low, i_stop_mode, o_detector_on, o_bandgap_buffer_enable;
  logic o_sys_reset_req, o_irq;
  int fails = 0, checked = 0, n;
  // 100 MHz clock
  initial forever #5 i_sys_clk = ~i_sys_clk;
  lvdc_supply_model #(.LAG_NS(7)) sup (.i_warn_cmd(warn), .i_detect_cmd(det),
    .i_stop_cmd(stop), .o_warn_low(i_warn_low), .o_detect_low(i_detect_low),
    .o_stop_mode(i_stop_mode));
  lvdc_top dut (.i_sys_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_warn_low, .i_detect_low, .i_stop_mode, .o_detector_on,
    .o_bandgap_buffer_enable, .o_sys_reset_req, .o_irq);
  task automatic test_done;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_sys_clk) begin i_wr <= 1'b1; i_addr <= a; i_wdata <= d; end
    @(posedge i_sys_clk) i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge i_sys_clk) begin i_rd <= 1'b1; i_addr <= a; end
    @(posedge i_sys_clk) i_rd <= 1'b0;
    #1 chk(o_rdata, exp);
  endtask
  task automatic do_reset;
    @(posedge i_sys_clk) i_rst <= 1'b1;
    cyc(12);
    @(posedge i_sys_clk) i_rst <= 1'b0;
  endtask
  // detect pulse; expect a request of len cycles, none when len is 0
  task automatic pulse_det(input int len);
    @(posedge i_sys_clk) det <= 1'b1;
    n = 0;
    while (o_sys_reset_req !== 1'b1 && n < 15) begin cyc(1); n++; end
    @(posedge i_sys_clk) det <= 1'b0;
    if (len == 0) chk(o_sys_reset_req, 0);
    else if (n == 15) begin fails++; test_done; end
    n = 1;
    while (o_sys_reset_req === 1'b1 && n < 30) begin cyc(1); n++; end
    if (len > 0) chk(n, len);
    cyc(5);
    chk(o_sys_reset_req, 0);
  endtask
  task automatic t_warn;
    @(posedge i_sys_clk) stop <= 1'b1;
    cyc(3);
    chk(o_detector_on, 1);
    @(posedge i_sys_clk) stop <= 1'b0;
    rd(4'h0, 8'h1C);
    rd(4'h4, 8'h00);
    @(posedge i_sys_clk) warn <= 1'b1;
    cyc(5);
    rd(4'h0, 8'h9C);
    wr(4'h0, 8'h5C);
    rd(4'h0, 8'h9C);
    @(posedge i_sys_clk) warn <= 1'b0;
    cyc(5);
    rd(4'h0, 8'h9C);
    wr(4'h0, 8'h3C);
    cyc(3);
    chk(o_irq, 1);
    wr(4'h0, 8'h7C);
    cyc(3);
    rd(4'h0, 8'h3C);
    chk(o_irq, 0);
    $display("warn test done");
  endtask
  task automatic t_once;
    pulse_det(10);
    wr(4'h0, 8'h01);
    rd(4'h0, 8'h1D);
    chk(o_bandgap_buffer_enable, 1);
    @(posedge i_sys_clk) warn <= 1'b1;
    do_reset;
    cyc(5);
    rd(4'h0, 8'h9C);
    @(posedge i_sys_clk) warn <= 1'b0;
    cyc(5);
    wr(4'h0, 8'h41);
    rd(4'h0, 8'h01);
    chk(o_detector_on, 0);
    wr(4'h0, 8'h1C);
    rd(4'h0, 8'h00);
    pulse_det(0);
    $display("once test done");
  endtask
  task automatic t_stop;
    do_reset;
    wr(4'h0, 8'h04);
    @(posedge i_sys_clk) stop <= 1'b1;
    cyc(3);
    rd(4'h0, 8'h04);
    chk(o_detector_on, 0);
    @(posedge i_sys_clk) stop <= 1'b0;
    cyc(3);
    chk(o_detector_on, 1);
    pulse_det(0);
    rd(4'h1, 8'h02);
    chk(o_irq, 0);
    wr(4'h2, 8'h02);
    cyc(3);
    chk(o_irq, 1);
    wr(4'h1, 8'h02);
    cyc(3);
    chk(o_irq, 0);
    rd(4'h3, 8'h00);
    $display("stop test done");
  endtask
  initial begin
    cyc(12);
    @(posedge i_sys_clk) i_rst <= 1'b0;
    cyc(2);
    t_warn;
    t_once;
    t_stop;
    test_done;
  end
endmodule // testbench
